/* src/rst_wake_ctrl.sv */
// Purpose: Reset and sleep/wake-up sequencing with an APB register file
// Assumes: One 40 MHz clock; pins arrive asynchronously
// Notes: Watchdog period equals the reset hold interval
//
// Local design decision: the APB interface to the registers.
`include "rst_wake_map.svh"
`timescale 1ns/100ps
`default_nettype none
module rst_wake_ctrl #(
    parameter int unsigned HOLD_CYCLES = `HOLD_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire rst_wake_pkg::apb_req_t apb_req,
    output var rst_wake_pkg::apb_rsp_t apb_rsp,
    // Pins and wake sources
    input wire logic ext_reset_n,
    input wire logic [7:0] port_b_pins,
    // Core side
    output logic core_reset,
    output logic core_sleeping,
    output logic core_vector_fetch,
    output logic [7:0] port_a_oe,
    output logic [7:0] port_b_oe
);
    import rst_wake_pkg::*;

    typedef struct packed {
        phase_t phase;
        logic por_pending;
        logic [2:0] rst_sync;
        logic [2:0][7:0] pb_sync;
        logic [7:0] pb_latch;
        logic [31:0] hold_cnt;
        logic [31:0] wdt_cnt;
        logic [7:0] prescaler;
        logic [7:0] timer_count;
        logic [7:0] program_counter;
        logic [7:0] status_word;
        logic [7:0] port_a_data;
        logic [7:0] port_b_data;
        logic [7:0] port_a_direction;
        logic [7:0] port_b_direction;
        logic [7:0] timer_prescale_control;
        logic [7:0] reserved_control;
        logic [7:0] pulldown_control;
        logic [7:0] open_drain_control;
        logic [7:0] pullhigh_control;
        logic [7:0] watchdog_control_reg;
        logic [7:0] interrupt_mask_reg;
        logic [7:0] interrupt_flag_reg;
        logic gie;
        logic pcwake_en;
        logic vector_fetch;
        logic sleep_slot_pc;
        apb_rsp_t rsp;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic wr_en;
    logic rd_en;
    logic pin_low;
    logic pin_stable;
    logic wdt_expire;
    logic pb_change;
    logic sleep_cmd;

    always_comb
    begin
        st_nxt = st_r;
        idx = apb_req.paddr[9:2];
        wdata = apb_req.pwdata[7:0];
        wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
        rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
        sleep_cmd = 1'b0;
        st_nxt.rst_sync = {st_r.rst_sync[1:0], ext_reset_n};
        st_nxt.pb_sync = {st_r.pb_sync[1:0], port_b_pins};
        // Act only once second and third stages agree
        pin_stable = st_r.rst_sync[1] == st_r.rst_sync[2];
        pin_low = pin_stable && !st_r.rst_sync[2];
        pb_change = (st_r.pb_sync[1] == st_r.pb_sync[2])
            && (((st_r.pb_sync[2] ^ st_r.pb_latch) & st_r.port_b_direction)
            != `ALL_ZERO);
        wdt_expire = st_r.watchdog_control_reg[`WDT_EN_BIT]
            && (st_r.wdt_cnt >= HOLD_CYCLES - 1);
        st_nxt.vector_fetch = 1'b0;
        st_nxt.rsp.pready = 1'b1;
        st_nxt.rsp.pslverr = 1'b0;
        // Watchdog free runs, also in sleep
        if (st_r.watchdog_control_reg[`WDT_EN_BIT])
            st_nxt.wdt_cnt = st_r.wdt_cnt + 32'd1;

        if (wr_en)
        begin
            unique case (idx)
                `IDX_TIMER_COUNT:
                begin
                    st_nxt.timer_count = wdata;
                    st_nxt.prescaler = `ALL_ZERO;
                end
                `IDX_PROGRAM_COUNTER: st_nxt.program_counter = wdata;
                `IDX_STATUS_WORD:
                    st_nxt.status_word = {wdata[7:5],
                        st_r.status_word[`STAT_TIMEOUT:`STAT_POWERDOWN],
                        wdata[2:0]};
                `IDX_PORT_A_DATA: st_nxt.port_a_data = wdata;
                `IDX_PORT_B_DATA: st_nxt.port_b_data = wdata;
                `IDX_RESERVED_CTRL: st_nxt.reserved_control = wdata;
                `IDX_PULLDOWN_CTRL: st_nxt.pulldown_control = wdata;
                `IDX_OPEN_DRAIN_CTRL: st_nxt.open_drain_control = wdata;
                `IDX_PULLHIGH_CTRL: st_nxt.pullhigh_control = wdata;
                `IDX_WATCHDOG_CTRL: st_nxt.watchdog_control_reg = wdata;
                `IDX_INT_MASK: st_nxt.interrupt_mask_reg = wdata;
                `IDX_PORT_A_DIR: st_nxt.port_a_direction = wdata;
                `IDX_PORT_B_DIR: st_nxt.port_b_direction = wdata;
                `IDX_TIMER_PRESCALE: st_nxt.timer_prescale_control = wdata;
                `IDX_INT_FLAG: st_nxt.interrupt_flag_reg = wdata;
                `IDX_CORE_CTRL:
                begin
                    st_nxt.gie = wdata[`CTRL_GIE];
                    st_nxt.pcwake_en = wdata[`CTRL_PCWAKE_EN];
                    sleep_cmd = wdata[`CTRL_SLEEP];
                    if (wdata[`CTRL_WDTCLR])
                    begin
                        st_nxt.wdt_cnt = 32'd0;
                        st_nxt.prescaler = `ALL_ZERO;
                        st_nxt.status_word[`STAT_TIMEOUT] = 1'b1;
                        st_nxt.status_word[`STAT_POWERDOWN] = 1'b1;
                    end
                end
                default: st_nxt.rsp.pslverr = 1'b1;
            endcase
        end

        if (rd_en)
        begin
            st_nxt.rsp.prdata = 32'h0000_0000;
            unique case (idx)
                `IDX_TIMER_COUNT: st_nxt.rsp.prdata[7:0] = st_r.timer_count;
                `IDX_PROGRAM_COUNTER:
                    st_nxt.rsp.prdata[7:0] = st_r.program_counter;
                `IDX_STATUS_WORD: st_nxt.rsp.prdata[7:0] = st_r.status_word;
                `IDX_PORT_A_DATA: st_nxt.rsp.prdata[7:0] = st_r.port_a_data;
                `IDX_PORT_B_DATA:
                begin
                    st_nxt.rsp.prdata[7:0] = st_r.pb_sync[2];
                    st_nxt.pb_latch = st_r.pb_sync[2];
                end
                `IDX_RESERVED_CTRL:
                    st_nxt.rsp.prdata[7:0] = st_r.reserved_control;
                `IDX_PULLDOWN_CTRL:
                    st_nxt.rsp.prdata[7:0] = st_r.pulldown_control;
                `IDX_OPEN_DRAIN_CTRL:
                    st_nxt.rsp.prdata[7:0] = st_r.open_drain_control;
                `IDX_PULLHIGH_CTRL:
                    st_nxt.rsp.prdata[7:0] = st_r.pullhigh_control;
                `IDX_WATCHDOG_CTRL:
                    st_nxt.rsp.prdata[7:0] = st_r.watchdog_control_reg;
                `IDX_INT_MASK:
                    st_nxt.rsp.prdata[7:0] = st_r.interrupt_mask_reg;
                `IDX_PORT_A_DIR:
                    st_nxt.rsp.prdata[7:0] = st_r.port_a_direction;
                `IDX_PORT_B_DIR:
                    st_nxt.rsp.prdata[7:0] = st_r.port_b_direction;
                `IDX_TIMER_PRESCALE:
                    st_nxt.rsp.prdata[7:0] = st_r.timer_prescale_control;
                `IDX_INT_FLAG:
                    st_nxt.rsp.prdata[7:0] = st_r.interrupt_flag_reg;
                `IDX_CORE_CTRL:
                    st_nxt.rsp.prdata[7:0] = {4'h0, st_r.pcwake_en,
                        st_r.gie, 1'b0, st_r.phase == SLEEP};
                `IDX_WDT_COUNT: st_nxt.rsp.prdata = st_r.wdt_cnt;
                `IDX_PRESCALER: st_nxt.rsp.prdata[7:0] = st_r.prescaler;
                default: st_nxt.rsp.prdata = 32'h0000_0000;
            endcase
        end

        unique case (st_r.phase)
            RUN:
            begin
                if (sleep_cmd)
                begin
                    st_nxt.phase = SLEEP;
                    st_nxt.wdt_cnt = 32'd0;
                    st_nxt.prescaler = `ALL_ZERO;
                    st_nxt.status_word[`STAT_TIMEOUT] = 1'b1;
                    st_nxt.status_word[`STAT_POWERDOWN] = 1'b0;
                end
            end
            SLEEP:
            begin
                st_nxt.sleep_slot_pc = 1'b1;
            end
            HOLD:
            begin
                st_nxt.hold_cnt = st_r.hold_cnt + 32'd1;
                // Watchdog restarts only once the core runs again
                st_nxt.wdt_cnt = 32'd0;
                if (st_r.hold_cnt >= HOLD_CYCLES - 1 && !pin_low)
                    st_nxt.phase = RUN;
            end
        endcase

        // Reset events: enter hold and load reset values
        if ((pin_low || wdt_expire) && st_r.phase != HOLD
            || pin_low && st_r.phase == HOLD)
        begin
            if (st_r.phase == SLEEP)
            begin
                st_nxt.status_word[`STAT_TIMEOUT] = !wdt_expire || pin_low;
                st_nxt.status_word[`STAT_POWERDOWN] = 1'b0;
            end
            else if (wdt_expire && !pin_low)
                st_nxt.status_word[`STAT_TIMEOUT] = 1'b0;
            st_nxt.phase = HOLD;
            st_nxt.hold_cnt = 32'd0;
            st_nxt.program_counter = `PC_RESET;
            st_nxt.port_a_direction = `ALL_ONES;
            st_nxt.port_b_direction = `ALL_ONES;
            st_nxt.wdt_cnt = 32'd0;
            st_nxt.prescaler = `ALL_ZERO;
            st_nxt.timer_count = `ALL_ZERO;
            st_nxt.status_word = st_nxt.status_word
                & `STAT_PAGE_MASK;
            st_nxt.timer_prescale_control = `TPC_RESET;
            st_nxt.reserved_control = `ALL_ONES;
            st_nxt.pulldown_control = `ALL_ONES;
            st_nxt.pullhigh_control = `ALL_ONES;
            st_nxt.open_drain_control = `ALL_ZERO;
            st_nxt.watchdog_control_reg = (st_r.watchdog_control_reg
                & `WDC_RESET_MASK) | `WDC_RESET_SET;
            st_nxt.interrupt_flag_reg = st_r.interrupt_flag_reg
                & `INT_LOW_MASK;
            st_nxt.interrupt_mask_reg = st_r.interrupt_mask_reg
                & `INT_LOW_MASK;
            st_nxt.gie = 1'b0;
            st_nxt.pcwake_en = 1'b0;
        end
        else if (st_r.phase == SLEEP && st_r.pcwake_en && pb_change)
        begin
            // Resume without reset; other registers keep value
            st_nxt.phase = RUN;
            st_nxt.pb_latch = st_r.pb_sync[2];
            st_nxt.status_word[`STAT_TIMEOUT] = 1'b1;
            st_nxt.status_word[`STAT_POWERDOWN] = 1'b0;
            st_nxt.watchdog_control_reg[`WDT_EN_BIT] = 1'b1;
            st_nxt.interrupt_flag_reg[1] = 1'b1;
            if (st_r.gie)
            begin
                st_nxt.program_counter = `PC_VECTOR;
                st_nxt.vector_fetch = 1'b1;
                st_nxt.gie = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Power-on values; flags read 1,1
            st_r <= '0;
            st_r.phase <= HOLD;
            st_r.por_pending <= 1'b1;
            st_r.rst_sync <= 3'b111;
            st_r.status_word <= 8'h18;
            st_r.port_a_direction <= `ALL_ONES;
            st_r.port_b_direction <= `ALL_ONES;
            st_r.timer_prescale_control <= `TPC_RESET;
            st_r.reserved_control <= `ALL_ONES;
            st_r.pulldown_control <= `ALL_ONES;
            st_r.pullhigh_control <= `ALL_ONES;
            st_r.watchdog_control_reg <= `WDC_RESET_SET;
            st_r.rsp.pready <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_reset <= 1'b1;
            core_sleeping <= 1'b0;
            core_vector_fetch <= 1'b0;
            port_a_oe <= `ALL_ZERO;
            port_b_oe <= `ALL_ZERO;
        end
        else
        begin
            core_reset <= st_nxt.phase == HOLD;
            core_sleeping <= st_nxt.phase == SLEEP;
            core_vector_fetch <= st_nxt.vector_fetch;
            port_a_oe <= ~st_nxt.port_a_direction;
            port_b_oe <= ~st_nxt.port_b_direction;
        end
    end

    assign apb_rsp = st_r.rsp;
endmodule
`default_nettype wire

/* src/rst_wake_map.svh */
// Purpose: Offsets, field positions, reset values, timing counts
// Assumes: pclk at 40 MHz
// Notes: Register word index times four gives the APB byte address
`ifndef RST_WAKE_MAP_SVH
`define RST_WAKE_MAP_SVH
`define IDX_TIMER_COUNT 8'h01
`define IDX_PROGRAM_COUNTER 8'h02
`define IDX_STATUS_WORD 8'h03
`define IDX_PORT_A_DATA 8'h05
`define IDX_PORT_B_DATA 8'h06
`define IDX_RESERVED_CTRL 8'h0a
`define IDX_PULLDOWN_CTRL 8'h0b
`define IDX_OPEN_DRAIN_CTRL 8'h0c
`define IDX_PULLHIGH_CTRL 8'h0d
`define IDX_WATCHDOG_CTRL 8'h0e
`define IDX_INT_MASK 8'h0f
`define IDX_PORT_A_DIR 8'h10
`define IDX_PORT_B_DIR 8'h11
`define IDX_TIMER_PRESCALE 8'h12
`define IDX_INT_FLAG 8'h13
`define IDX_CORE_CTRL 8'h14
`define IDX_WDT_COUNT 8'h15
`define IDX_PRESCALER 8'h16
`define STAT_TIMEOUT 4
`define STAT_POWERDOWN 3
`define STAT_PAGE_MASK 8'h1f
`define WDT_EN_BIT 7
`define TPC_RESET 8'hbf
`define WDC_RESET_MASK 8'h2f
`define WDC_RESET_SET 8'h80
`define INT_LOW_MASK 8'hf8
`define PC_RESET 8'h00
`define PC_VECTOR 8'h08
`define ALL_ONES 8'hff
`define ALL_ZERO 8'h00
`define HOLD_TIME_US 18000
`define CLK_MHZ 40
`define HOLD_CYCLES (`HOLD_TIME_US * `CLK_MHZ)
`define CTRL_SLEEP 0
`define CTRL_WDTCLR 1
`define CTRL_GIE 2
`define CTRL_PCWAKE_EN 3
`endif

/* src/rst_wake_pkg.sv */
// Purpose: Types for the reset and wake-up sequencer
// Assumes: Nothing
// Notes: State and APB carriers
package rst_wake_pkg;
    typedef enum logic [1:0] {RUN, HOLD, SLEEP} phase_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;
endpackage

/* test/core_model.sv */
// Purpose: Pin-side partner driving reset pin and port B inputs
// Assumes: Driven right after rising pclk edges
// Notes: Pins hold their level between calls, as real pads would
`timescale 1ns/100ps
`default_nettype none
module core_model (
    // Clock
    input wire logic pclk,
    // Pins toward the block
    output logic ext_reset_n,
    output logic [7:0] port_b_pins
);
    initial
    begin
        ext_reset_n = 1'b1;
        port_b_pins = 8'h00;
    end
    task automatic pulse_reset(input int cycles);
        @(posedge pclk);
        ext_reset_n <= 1'b0;
        repeat (cycles) @(posedge pclk);
        ext_reset_n <= 1'b1;
    endtask
    task automatic flip_pin(input int b);
        @(posedge pclk);
        port_b_pins[b] <= ~port_b_pins[b];
    endtask
endmodule
`default_nettype wire

/* test/rst_wake_checker.sv */
// Purpose: Concurrent checks on the reset and wake-up sequencer
// Assumes: Single pclk domain
// Notes: Bound to the top module from the testbench file
`include "rst_wake_map.svh"
`timescale 1ns/100ps
`default_nettype none
module rst_wake_checker #(
    parameter int unsigned HOLD_CYCLES = 64
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire rst_wake_pkg::apb_req_t apb_req,
    input wire rst_wake_pkg::apb_rsp_t apb_rsp,
    // Pins
    input wire logic ext_reset_n,
    input wire logic [7:0] port_b_pins,
    // Core side
    input wire logic core_reset,
    input wire logic core_sleeping,
    input wire logic core_vector_fetch,
    input wire logic [7:0] port_a_oe,
    input wire logic [7:0] port_b_oe
);
    import rst_wake_pkg::*;
    logic [31:0] hold_cnt_r;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_cnt_r <= '0;
        else if (core_reset)
            hold_cnt_r <= hold_cnt_r + 32'h1;
        else
            hold_cnt_r <= '0;
    end
    sequence s_pin_low;
        (!ext_reset_n) [*8];
    endsequence
    sequence s_sleep_write;
        apb_req.psel && apb_req.penable && apb_req.pwrite &&
        apb_req.paddr == {22'h0, `IDX_CORE_CTRL, 2'b00} &&
        apb_req.pwdata[0] && !core_reset;
    endsequence
    property p_pin_reset;
        s_pin_low |-> ##[0:2] core_reset;
    endproperty
    a_pin_reset: assert property (p_pin_reset)
        else $error("pin low did not reset core");
    // Pin-held resets may stretch the hold, hence the wide upper margin
    property p_hold_len;
        $fell(core_reset) |-> hold_cnt_r >= HOLD_CYCLES - 2 &&
            hold_cnt_r <= HOLD_CYCLES + 20;
    endproperty
    a_hold_len: assert property (p_hold_len)
        else $error("reset hold length wrong");
    property p_oe_off;
        core_reset [*3] |-> port_a_oe == 8'h00 && port_b_oe == 8'h00;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("pin driven during reset");
    property p_no_sleep_in_reset;
        core_reset ##1 core_reset |-> !core_sleeping;
    endproperty
    a_no_sleep_in_reset: assert property (p_no_sleep_in_reset)
        else $error("sleeping while in reset");
    property p_sleep_entry;
        s_sleep_write |-> ##[1:2] core_sleeping;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("sleep write did not enter sleep");
    property p_vector_pulse;
        core_vector_fetch |=> !core_vector_fetch;
    endproperty
    a_vector_pulse: assert property (p_vector_pulse)
        else $error("vector fetch longer than one cycle");
    property p_vector_cause;
        core_vector_fetch |-> !core_reset &&
            ($past(core_sleeping) || $past(core_sleeping, 2));
    endproperty
    a_vector_cause: assert property (p_vector_cause)
        else $error("vector fetch without sleep wake");
    property p_pready;
        apb_req.psel && apb_req.penable |-> apb_rsp.pready;
    endproperty
    a_pready: assert property (p_pready)
        else $error("pready low in access");
    property p_pslverr;
        apb_rsp.pslverr |-> $past(apb_req.psel && apb_req.penable);
    endproperty
    a_pslverr: assert property (p_pslverr)
        else $error("pslverr without access");
endmodule
`default_nettype wire

/* test/testbench.sv */
// Purpose: Self-checking bench for the reset and wake-up sequencer
// Assumes: Hold and watchdog period shortened to 64 cycles
// Notes: Watchdog runs out of reset, so firmware disables it early
`include "rst_wake_map.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import rst_wake_pkg::*;
    localparam int unsigned HOLD = 64;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    logic ext_reset_n, core_reset, core_sleeping, core_vector_fetch, v;
    logic [7:0] port_b_pins, port_a_oe, port_b_oe, rd;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;
    logic [23:0] tbl [11] = '{{`IDX_PROGRAM_COUNTER, 16'hff00},
        {`IDX_TIMER_COUNT, 16'hff00}, {`IDX_TIMER_PRESCALE, 16'hffbf},
        {`IDX_RESERVED_CTRL, 16'hffff}, {`IDX_PULLDOWN_CTRL, 16'hf7f7},
        {`IDX_OPEN_DRAIN_CTRL, 16'hff00}, {`IDX_PULLHIGH_CTRL, 16'hffff},
        {`IDX_INT_MASK, 16'h0700}, {`IDX_INT_FLAG, 16'h0700},
        {`IDX_PORT_A_DIR, 16'h0f0f}, {`IDX_PORT_B_DIR, 16'hffff}};
    always #12.5 pclk = ~pclk;
    rst_wake_ctrl #(.HOLD_CYCLES(HOLD)) i_dut (.pclk(pclk),
        .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .ext_reset_n(ext_reset_n), .port_b_pins(port_b_pins),
        .core_reset(core_reset), .core_sleeping(core_sleeping),
        .core_vector_fetch(core_vector_fetch), .port_a_oe(port_a_oe),
        .port_b_oe(port_b_oe));
    core_model i_core (.pclk(pclk), .ext_reset_n(ext_reset_n),
        .port_b_pins(port_b_pins));
    task automatic chk(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic xfer(input logic [7:0] idx, input logic wr,
        input logic [7:0] wd);
        @(posedge pclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= {22'h0, idx, 2'b00};
        req.pwdata <= {24'h0, wd};
        @(posedge pclk);
        req.penable <= 1'b1;
        do
            @(posedge pclk);
        while (rsp.pready !== 1'b1);
        rd = rsp.prdata[7:0];
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    // Entry: index, mask, expected value under the mask
    task automatic rchk(input logic [23:0] e);
        xfer(e[23:16], 1'b0, 8'h00);
        chk($sformatf("reg_%h", e[23:16]), rd & e[15:8], e[7:0]);
    endtask
    task automatic wait_rst(input logic lvl);
        n = 0;
        while (core_reset !== lvl && n < 300)
        begin
            @(posedge pclk);
            n++;
        end
        chk("core_reset", 8'(core_reset), 8'(lvl));
    endtask
    task automatic end_sim;
        $display("Checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            end_sim();
        end
    end
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        wait_rst(1'b0);
        chk("hold", 8'(n >= HOLD - 4 && n <= HOLD + 4), 8'h01);
        rchk({`IDX_STATUS_WORD, 16'hf818});
        wait_rst(1'b1);
        wait_rst(1'b0);
        rchk({`IDX_STATUS_WORD, 16'h1808});
        rchk({`IDX_WATCHDOG_CTRL, 16'hd080});
        xfer(`IDX_WATCHDOG_CTRL, 1'b1, 8'h00);
        foreach (tbl[i])
            rchk(tbl[i]);
        chk("port_b_oe", port_b_oe, 8'h00);
        $display("Test reset values done");
        rchk({8'h3f, 16'hff00});
        xfer(8'h3f, 1'b1, 8'h55);
        @(posedge pclk);
        chk("pslverr", 8'(rsp.pslverr), 8'h01);
        $display("Test unmapped done");
        for (int g = 1; g >= 0; g--)
        begin
            xfer(`IDX_TIMER_COUNT, 1'b1, 8'h5a);
            xfer(`IDX_WATCHDOG_CTRL, 1'b1, 8'h00);
            xfer(`IDX_INT_MASK, 1'b1, 8'h02);
            xfer(`IDX_PORT_B_DATA, 1'b0, 8'h00);
            xfer(`IDX_CORE_CTRL, 1'b1, {4'h0, 1'b1, g[0], 2'b01});
            rchk({`IDX_STATUS_WORD, 16'h1810});
            chk("sleeping", 8'(core_sleeping), 8'h01);
            i_core.flip_pin(3);
            v = 1'b0;
            for (int k = 0; k < 40; k++)
            begin
                @(posedge pclk);
                v = v | core_vector_fetch;
            end
            chk("vector", 8'(v), 8'(g[0]));
            chk("awake", 8'({core_reset, core_sleeping}), 8'h00);
            rchk({`IDX_STATUS_WORD, 16'h1810});
            rchk({`IDX_WATCHDOG_CTRL, 16'h8080});
            rchk({`IDX_TIMER_COUNT, 16'hff5a});
        end
        $display("Test port change wake done");
        xfer(`IDX_PORT_A_DIR, 1'b1, 8'h00);
        repeat (2) @(posedge pclk);
        chk("port_a_oe", port_a_oe & 8'h0f, 8'h0f);
        xfer(`IDX_WATCHDOG_CTRL, 1'b1, 8'h80);
        xfer(`IDX_CORE_CTRL, 1'b1, 8'h01);
        wait_rst(1'b1);
        wait_rst(1'b0);
        rchk({`IDX_STATUS_WORD, 16'h1800});
        rchk({`IDX_PROGRAM_COUNTER, 16'hff00});
        chk("port_a_oe", port_a_oe, 8'h00);
        $display("Test watchdog wake done");
        xfer(`IDX_WATCHDOG_CTRL, 1'b1, 8'h00);
        xfer(`IDX_CORE_CTRL, 1'b1, 8'h01);
        i_core.pulse_reset(10);
        wait_rst(1'b1);
        wait_rst(1'b0);
        rchk({`IDX_STATUS_WORD, 16'h1810});
        $display("Test pin wake done");
        end_sim();
    end
endmodule
bind rst_wake_ctrl rst_wake_checker #(.HOLD_CYCLES(HOLD_CYCLES)) i_chk (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .ext_reset_n(ext_reset_n), .port_b_pins(port_b_pins),
    .core_reset(core_reset), .core_sleeping(core_sleeping),
    .core_vector_fetch(core_vector_fetch), .port_a_oe(port_a_oe),
    .port_b_oe(port_b_oe));
`default_nettype wire
